// file: core/dtf_apb_slave.sv
`timescale 1ns/1ps
`include "dtf_params.svh"

// Zero-wait APB slave front end: decodes a byte index and qualifies strobes
module dtf_apb_slave (
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire dtf_pkg::dtf_apb_req_s req,
	input  wire logic [7:0]            rd_byte,
	output logic                       wr_stb,
	output logic                       rd_stb,
	output logic [3:0]                 idx,
	output logic [7:0]                 wr_byte,
	output dtf_pkg::dtf_apb_rsp_s      rsp
);
	import dtf_pkg::*;

	logic unmapped;
	logic access;

	assign idx      = req.paddr[5:2];
	assign unmapped = (req.paddr[31:6] != 26'h000_0000) || (req.paddr[1:0] != 2'b00) || (idx > `DTF_IDX_LAST);
	assign access   = req.psel && req.penable;
	assign wr_stb   = access && req.pwrite && req.pstrb[0] && !unmapped;
	assign rd_stb   = access && !req.pwrite && !unmapped;
	assign wr_byte  = req.pwdata[7:0];

	always_comb begin
		rsp.pready  = 1'b1;
		rsp.pslverr = access && unmapped;
		rsp.prdata  = rd_stb ? {24'h00_0000, rd_byte} : `DTF_ZERO32;
	end

	logic unused_ok;
	assign unused_ok = rst ^ clock ^ (^req.pstrb[3:1]);

endmodule : dtf_apb_slave

// file: core/dtf_dir_ctrl.sv
`timescale 1ns/1ps
`include "dtf_params.svh"

// Fault state machine with pin direction save and restore
module dtf_dir_ctrl (
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic       fault_hit,
	input  wire logic       fault_cond,
	input  wire logic       fault_flag,
	input  wire logic       restart_mode,
	input  wire logic [1:0] action,
	input  wire logic [7:0] chan_pin_mask,
	input  wire logic       update,
	input  wire logic [7:0] port_dir_in,
	output logic [7:0]      dir_out,
	output logic            fault_active
);
	import dtf_pkg::*;

	typedef struct packed {
		dtf_fault_e st;
		logic [7:0] saved;
		logic [7:0] dir;
	} dtf_dir_s;

	dtf_dir_s cur_ff, nxt_cur;
	logic     released;

	always_comb begin
		nxt_cur  = cur_ff;
		released = restart_mode ? !fault_cond : (!fault_cond && !fault_flag); // [RL16]
		case (cur_ff.st)
			DTF_NORMAL: begin
				nxt_cur.dir = port_dir_in;
				if (fault_hit && action == `DTF_ACT_CLEARDIR) begin
					nxt_cur.st    = DTF_FAULT;
					nxt_cur.saved = port_dir_in;
					nxt_cur.dir   = port_dir_in & ~chan_pin_mask; // [RL17]
				end
			end
			DTF_FAULT: begin
				nxt_cur.dir = (port_dir_in & ~chan_pin_mask);
				if (released)
					nxt_cur.st = DTF_WAIT_UPD;
			end
			DTF_WAIT_UPD: begin
				nxt_cur.dir = (port_dir_in & ~chan_pin_mask);
				if (fault_hit)
					nxt_cur.st = DTF_FAULT;
				else if (update) begin // [RL16]
					nxt_cur.st  = DTF_NORMAL;
					nxt_cur.dir = (port_dir_in & ~chan_pin_mask) | (cur_ff.saved & chan_pin_mask); // [RL18]
				end
			end
			default: nxt_cur.st = DTF_NORMAL;
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst)
			cur_ff <= '{st: DTF_NORMAL, saved: `DTF_ZERO8, dir: `DTF_ZERO8};
		else
			cur_ff <= nxt_cur;
	end

	assign dir_out      = cur_ff.dir;
	assign fault_active = (cur_ff.st != DTF_NORMAL);

endmodule : dtf_dir_ctrl

// file: core/dtf_reg_bank.sv
`timescale 1ns/1ps
`include "dtf_params.svh"

// Functional notes
// RL1: Masked fault event sets fault detect flag
// RL2: Write one clears flag; zero keeps it
// RL3: Valid buffer copies to active at UPDATE
// RL4: No valid flag means no transfer
// RL5: Lock update flag blocks buffer transfer
// RL6: Both-sides alias writes both active registers
// RL7: Both-buffers alias writes both buffers
// RL8: Low-side value is dead-time cycle count
// RL9: High-side value is dead-time cycle count
// RL10: Low-side buffer moves in at UPDATE
// RL11: High-side buffer moves in at UPDATE
// RL12: Override writes blocked while flag set
// RL13: Override bit maps one-to-one to pin
// RL14: Override replaces output value, never direction
// RL15: Software writes zero to reserved status bits
// RL16: Restart mode picks latched or cycle recovery
// RL17: Action 11 tri-states enabled channel pins
// RL18: Leaving fault restores saved direction bits
// RL19: Buffer write sets valid; transfer clears it
// RL20: Reset to zero; reserved offsets read zero
module dtf_reg_bank (
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire dtf_pkg::dtf_apb_req_s apb_req,
	output dtf_pkg::dtf_apb_rsp_s      apb_rsp,
	input  wire logic [7:0]            event_chan,
	input  wire logic                  update,
	input  wire logic                  lock_update_flag,
	input  wire logic                  debug_break,
	input  wire logic [7:0]            port_out_in,
	input  wire logic [7:0]            port_dir_in,
	input  wire logic [7:0]            waveform_in,
	output logic [7:0]                 pin_out,
	output logic [7:0]                 pin_dir,
	output logic [7:0]                 low_side_dead_time,
	output logic [7:0]                 high_side_dead_time,
	output logic                       pattern_generation_mode,
	output logic                       common_waveform_channel_mode,
	output logic                       fault_active
);
	import dtf_pkg::*;

	// Each pair of pins belongs to one dead-time channel
	function automatic logic [7:0] chan_pins(input logic [3:0] en);
		logic [7:0] p;
		p = `DTF_ZERO8;
		for (int i = 0; i < 4; i++)
			p[2*i +: 2] = {2{en[i]}};
		return p;
	endfunction : chan_pins

	function automatic logic is_idx(input logic [3:0] a, input logic [3:0] b);
		return a == b;
	endfunction : is_idx

	dtf_regs_s  regs_ff, nxt_regs;
	logic       wr_stb;
	logic       rd_stb;
	logic [3:0] idx;
	logic [7:0] wr_byte;
	logic [7:0] rd_byte;
	logic       fault_hit;
	logic       fault_cond;
	logic       xfer_ok;
	logic [7:0] chan_pin_mask;
	logic [1:0] action;
	logic       brk_fault;

	dtf_apb_slave u_apb (
		.clock   (clock),
		.rst     (rst),
		.req     (apb_req),
		.rd_byte (rd_byte),
		.wr_stb  (wr_stb),
		.rd_stb  (rd_stb),
		.idx     (idx),
		.wr_byte (wr_byte),
		.rsp     (apb_rsp)
	);

	assign action     = regs_ff.fdet_ctl[`DTF_FD_ACT_HI:`DTF_FD_ACT_LO];
	assign brk_fault  = debug_break && !regs_ff.fdet_ctl[`DTF_FD_IGN_BRK];
	// Events are ORed after masking; protection off when action is NONE
	assign fault_cond = (|(event_chan & regs_ff.mask)) || brk_fault;
	assign fault_hit  = fault_cond && (action != `DTF_ACT_NONE);
	assign xfer_ok    = update && !lock_update_flag; // [RL5]
	assign chan_pin_mask = chan_pins(regs_ff.ctrl[`DTF_CH_EN_HI:`DTF_CH_EN_LO]);

	// Register read mux: reserved offsets and bits return zero
	always_comb begin
		rd_byte = `DTF_ZERO8; // [RL20]
		if (is_idx(idx, `DTF_IDX_CTRL))
			rd_byte = regs_ff.ctrl;
		else if (is_idx(idx, `DTF_IDX_MASK))
			rd_byte = regs_ff.mask;
		else if (is_idx(idx, `DTF_IDX_FDET_CTL))
			rd_byte = regs_ff.fdet_ctl;
		else if (is_idx(idx, `DTF_IDX_STATUS))
			rd_byte = {5'b0_0000, regs_ff.fault_flag, regs_ff.hsv, regs_ff.lsv}; // [RL15]
		else if (is_idx(idx, `DTF_IDX_BOTH_DT) || is_idx(idx, `DTF_IDX_LO_DT))
			rd_byte = regs_ff.lo_dt;
		else if (is_idx(idx, `DTF_IDX_BOTH_BUF) || is_idx(idx, `DTF_IDX_LO_BUF))
			rd_byte = regs_ff.lo_dt_buf;
		else if (is_idx(idx, `DTF_IDX_HI_DT))
			rd_byte = regs_ff.hi_dt;
		else if (is_idx(idx, `DTF_IDX_HI_BUF))
			rd_byte = regs_ff.hi_dt_buf;
		else if (is_idx(idx, `DTF_IDX_OVEN))
			rd_byte = regs_ff.oven;
	end

	always_comb begin
		nxt_regs = regs_ff;

		// Buffered transfer first, so a same-cycle bus write takes priority after it
		if (xfer_ok && regs_ff.lsv) begin // [RL3] [RL4] [RL10]
			nxt_regs.lo_dt = regs_ff.lo_dt_buf;
			nxt_regs.lsv   = 1'b0; // [RL19]
		end
		if (xfer_ok && regs_ff.hsv) begin // [RL3] [RL4] [RL11]
			nxt_regs.hi_dt = regs_ff.hi_dt_buf;
			nxt_regs.hsv   = 1'b0; // [RL19]
		end

		if (wr_stb) begin
			if (is_idx(idx, `DTF_IDX_CTRL))
				nxt_regs.ctrl = wr_byte & `DTF_CTRL_MASK;
			else if (is_idx(idx, `DTF_IDX_MASK))
				nxt_regs.mask = wr_byte;
			else if (is_idx(idx, `DTF_IDX_FDET_CTL))
				nxt_regs.fdet_ctl = wr_byte & `DTF_FDET_CTL_MASK;
			else if (is_idx(idx, `DTF_IDX_STATUS)) begin
				if (wr_byte[`DTF_ST_FAULT])
					nxt_regs.fault_flag = 1'b0; // [RL2]
				if (wr_byte[`DTF_ST_LSV])
					nxt_regs.lsv = 1'b0;
				if (wr_byte[`DTF_ST_HSV])
					nxt_regs.hsv = 1'b0;
			end else if (is_idx(idx, `DTF_IDX_BOTH_DT)) begin
				nxt_regs.lo_dt = wr_byte; // [RL6]
				nxt_regs.hi_dt = wr_byte; // [RL6]
			end else if (is_idx(idx, `DTF_IDX_BOTH_BUF)) begin
				nxt_regs.lo_dt_buf = wr_byte; // [RL7]
				nxt_regs.hi_dt_buf = wr_byte; // [RL7]
				nxt_regs.lsv       = 1'b1; // [RL19]
				nxt_regs.hsv       = 1'b1; // [RL19]
			end else if (is_idx(idx, `DTF_IDX_LO_DT))
				nxt_regs.lo_dt = wr_byte;
			else if (is_idx(idx, `DTF_IDX_HI_DT))
				nxt_regs.hi_dt = wr_byte;
			else if (is_idx(idx, `DTF_IDX_LO_BUF)) begin
				nxt_regs.lo_dt_buf = wr_byte;
				nxt_regs.lsv       = 1'b1; // [RL19]
			end else if (is_idx(idx, `DTF_IDX_HI_BUF)) begin
				nxt_regs.hi_dt_buf = wr_byte;
				nxt_regs.hsv       = 1'b1; // [RL19]
			end else if (is_idx(idx, `DTF_IDX_OVEN) && !regs_ff.fault_flag)
				nxt_regs.oven = wr_byte; // [RL12]
		end

		// Set wins over a clear in the same cycle
		if (fault_cond)
			nxt_regs.fault_flag = 1'b1; // [RL1]
	end

	always_ff @(posedge clock) begin
		if (rst)
			regs_ff <= '0; // [RL20]
		else
			regs_ff <= nxt_regs;
	end

	dtf_dir_ctrl u_dir (
		.clock        (clock),
		.rst          (rst),
		.fault_hit    (fault_hit),
		.fault_cond   (fault_cond),
		.fault_flag   (regs_ff.fault_flag),
		.restart_mode (regs_ff.fdet_ctl[`DTF_FD_MODE]),
		.action       (action),
		.chan_pin_mask (chan_pin_mask),
		.update       (update),
		.port_dir_in  (port_dir_in),
		.dir_out      (pin_dir), // [RL14]
		.fault_active (fault_active)
	);

	// Output value per pin: override selects the waveform bit at the same position
	logic [7:0] nxt_pin_out;
	logic [7:0] pin_out_ff;

	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_ovr
			assign nxt_pin_out[g] = regs_ff.oven[g] ? waveform_in[g] : port_out_in[g]; // [RL13] [RL14]
		end
	endgenerate

	always_ff @(posedge clock) begin
		if (rst)
			pin_out_ff <= `DTF_ZERO8;
		else
			pin_out_ff <= nxt_pin_out;
	end

	assign pin_out                      = pin_out_ff;
	assign low_side_dead_time           = regs_ff.lo_dt; // [RL8]
	assign high_side_dead_time          = regs_ff.hi_dt; // [RL9]
	assign pattern_generation_mode      = regs_ff.ctrl[`DTF_CTRL_PAT];
	assign common_waveform_channel_mode = regs_ff.ctrl[`DTF_CTRL_COM];

	logic unused_ok;
	assign unused_ok = rd_stb;

endmodule : dtf_reg_bank

// file: dv/dtf_partner.sv
`timescale 1ns/1ps
// Timer side: one-cycle update pulse on request, free-running waveform and port value
module dtf_partner (
	input  wire logic  clock,
	input  wire logic  rst,
	input  wire logic  fire,
	output logic       update,
	output logic [7:0] waveform_in,
	output logic [7:0] port_out_in
);
	always_ff @(posedge clock) begin
		update      <= fire && !rst;
		waveform_in <= rst ? 8'h00 : waveform_in + 8'h01;
		port_out_in <= rst ? 8'h00 : (waveform_in + 8'h01) ^ 8'h33;
	end
endmodule : dtf_partner

// file: dv/dtf_reg_bank_props.sv
`timescale 1ns/1ps
module dtf_reg_bank_props (
	input wire logic                  clock,
	input wire logic                  rst,
	input wire dtf_pkg::dtf_apb_req_s apb_req,
	input wire dtf_pkg::dtf_apb_rsp_s apb_rsp,
	input wire logic                  update,
	input wire logic                  lock_update_flag,
	input wire logic [7:0]            port_out_in,
	input wire logic [7:0]            port_dir_in,
	input wire logic [7:0]            waveform_in,
	input wire logic [7:0]            pin_out,
	input wire logic [7:0]            pin_dir,
	input wire logic [7:0]            low_side_dead_time,
	input wire logic [7:0]            high_side_dead_time,
	input wire logic                  fault_active
);
	import dtf_pkg::*;
	logic acc;
	logic wr;
	assign acc = apb_req.psel && apb_req.penable;
	assign wr  = acc && apb_req.pwrite && apb_req.pstrb[0];
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_rsvd_read: assert property (acc && !apb_req.pwrite && (apb_req.paddr[7:0] == 8'h04
		|| apb_req.paddr[7:0] == 8'h14) |-> apb_rsp.prdata == 32'h0000_0000) else $error("reserved read not zero");
	a_both_alias: assert property (wr && apb_req.paddr == 32'h0000_0018 |=>
		low_side_dead_time == $past(apb_req.pwdata[7:0]) && high_side_dead_time == low_side_dead_time)
		else $error("alias write missed a side");
	a_low_count: assert property (wr && apb_req.paddr == 32'h0000_0020 |=>
		low_side_dead_time == $past(apb_req.pwdata[7:0])) else $error("low side write lost");
	a_high_count: assert property (wr && apb_req.paddr == 32'h0000_0024 |=>
		high_side_dead_time == $past(apb_req.pwdata[7:0])) else $error("high side write lost");
	a_lock_hold: assert property (update && lock_update_flag && !wr |=>
		$stable(low_side_dead_time) && $stable(high_side_dead_time)) else $error("transfer under lock");
	a_idle_hold: assert property (!update && !wr |=>
		$stable(low_side_dead_time) && $stable(high_side_dead_time)) else $error("active value moved");
	a_pin_out_map: assert property (##1 ((pin_out ^ $past(port_out_in))
		& ~$past(waveform_in ^ port_out_in)) == 8'h00) else $error("pin output not from its sources");
	a_dir_pass: assert property (!fault_active && !$past(fault_active) && !$past(rst) |->
		pin_dir == $past(port_dir_in)) else $error("direction altered outside fault");
endmodule : dtf_reg_bank_props

// file: dv/dtf_reg_bank_test.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_errors++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module dtf_reg_bank_test;
	import dtf_pkg::*;
	logic         clock = 1'b0;
	logic         rst = 1'b1;
	dtf_apb_req_s apb_req = '0;
	dtf_apb_rsp_s apb_rsp;
	logic [7:0]   event_chan = 8'h00;
	logic         lock_update_flag = 1'b0;
	logic [7:0]   port_dir_in = 8'hFF;
	logic         fire = 1'b0;
	logic         update;
	logic [7:0]   waveform_in, port_out_in, pin_out, pin_dir, e;
	logic [7:0]   low_side_dead_time, high_side_dead_time;
	logic         fault_active, serr, pat_mode, com_mode;
	logic [31:0]  rdata;
	int           n_errors = 0;
	int           n_checks = 0;
	int           cyc = 0;
	always #5 clock = ~clock;
	dtf_partner tc (.clock, .rst, .fire, .update, .waveform_in, .port_out_in);
	dtf_reg_bank dut (.clock, .rst, .apb_req, .apb_rsp, .event_chan, .update, .lock_update_flag,
		.debug_break(1'b0), .port_out_in, .port_dir_in, .waveform_in, .pin_out, .pin_dir,
		.low_side_dead_time, .high_side_dead_time, .pattern_generation_mode(pat_mode),
		.common_waveform_channel_mode(com_mode), .fault_active);
	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			n_errors++;
			report_and_stop;
		end
	end
	// Idle cycle after each transfer so psel is never driven twice in one step
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		apb_req <= '{{24'h00_0000, a}, 1'b1, 1'b0, w, {24'h00_0000, d}, 4'hF};
		@(posedge clock);
		apb_req.penable <= 1'b1;
		do @(posedge clock); while (apb_rsp.pready !== 1'b1);
		rdata = apb_rsp.prdata;
		serr = apb_rsp.pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
		@(posedge clock);
	endtask : bus
	task automatic rchk(input logic [7:0] a, input logic [7:0] x);
		bus(1'b0, a, 8'h00);
		`CHK("prdata", {24'h00_0000, x}, rdata)
	endtask : rchk
	task automatic upd;
		fire <= 1'b1;
		@(posedge clock);
		fire <= 1'b0;
		repeat (4) @(posedge clock);
	endtask : upd
	task automatic hit;
		event_chan <= 8'h04;
		@(posedge clock);
		event_chan <= 8'h00;
		repeat (4) @(posedge clock);
	endtask : hit
	task automatic t_reset;
		for (int i = 0; i <= 12; i++) rchk(8'(i * 4), 8'h00);
		`CHK("pattern", 1'b0, pat_mode)
		`CHK("common", 1'b0, com_mode)
		bus(1'b1, 8'h14, 8'hFF);
		rchk(8'h14, 8'h00);
		bus(1'b1, 8'h34, 8'h5A);
		`CHK("pslverr", 1'b1, serr)
	endtask : t_reset
	task automatic t_buffers;
		bus(1'b1, 8'h18, 8'h3C);
		`CHK("low", 8'h3C, low_side_dead_time)
		`CHK("high", 8'h3C, high_side_dead_time)
		bus(1'b1, 8'h1C, 8'hA5);
		rchk(8'h28, 8'hA5);
		rchk(8'h2C, 8'hA5);
		rchk(8'h10, 8'h03);
		lock_update_flag <= 1'b1;
		upd;
		`CHK("high", 8'h3C, high_side_dead_time)
		rchk(8'h10, 8'h03);
		lock_update_flag <= 1'b0;
		upd;
		`CHK("low", 8'hA5, low_side_dead_time)
		`CHK("high", 8'hA5, high_side_dead_time)
		rchk(8'h10, 8'h00);
		bus(1'b1, 8'h28, 8'h11);
		bus(1'b1, 8'h24, 8'h77);
		`CHK("high", 8'h77, high_side_dead_time)
		rchk(8'h10, 8'h01);
		upd;
		`CHK("low", 8'h11, low_side_dead_time)
		`CHK("high", 8'h77, high_side_dead_time)
	endtask : t_buffers
	task automatic t_fault;
		bus(1'b1, 8'h30, 8'hF0);
		e = (waveform_in & 8'hF0) | (port_out_in & 8'h0F);
		#1;
		`CHK("pin_out", e, pin_out)
		@(posedge clock);
		bus(1'b1, 8'h00, 8'h01);
		bus(1'b1, 8'h08, 8'h04);
		bus(1'b1, 8'h0C, 8'h00);
		hit;
		`CHK("pin_dir", 8'hFF, pin_dir)
		bus(1'b1, 8'h10, 8'h04);
		bus(1'b1, 8'h0C, 8'h03);
		hit;
		rchk(8'h10, 8'h04);
		`CHK("pin_dir", 8'hFC, pin_dir)
		bus(1'b1, 8'h30, 8'h0F);
		rchk(8'h30, 8'hF0);
		bus(1'b1, 8'h10, 8'h00);
		rchk(8'h10, 8'h04);
		upd;
		`CHK("latched", 1'b1, fault_active)
		bus(1'b1, 8'h10, 8'h04);
		rchk(8'h10, 8'h00);
		// Port direction moves during the fault, so the restore must use the saved bits
		port_dir_in <= 8'hF0;
		fire <= 1'b1;
		@(posedge clock);
		fire <= 1'b0;
		@(posedge clock);
		#1;
		`CHK("pin_dir", 8'hF3, pin_dir)
		`CHK("fault_active", 1'b0, fault_active)
		@(posedge clock);
		#1;
		`CHK("pin_dir", 8'hF0, pin_dir)
		@(posedge clock);
		port_dir_in <= 8'hFF;
		@(posedge clock);
		bus(1'b1, 8'h30, 8'h0F);
		rchk(8'h30, 8'h0F);
		bus(1'b1, 8'h0C, 8'h07);
		hit;
		`CHK("pin_dir", 8'hFC, pin_dir)
		upd;
		`CHK("cycle", 1'b0, fault_active)
		`CHK("pin_dir", 8'hFF, pin_dir)
	endtask : t_fault
	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_reset;
		t_buffers;
		t_fault;
		report_and_stop;
	end
endmodule : dtf_reg_bank_test
bind dtf_reg_bank dtf_reg_bank_props props (.clock, .rst, .apb_req, .apb_rsp, .update, .lock_update_flag,
	.port_out_in, .port_dir_in, .waveform_in, .pin_out, .pin_dir, .low_side_dead_time,
	.high_side_dead_time, .fault_active);

// file: include/dtf_params.svh
`ifndef DTF_PARAMS_SVH
`define DTF_PARAMS_SVH

// Byte indices of the registers; APB byte address is four times the index
`define DTF_IDX_CTRL      4'h0
`define DTF_IDX_RSVD1     4'h1
`define DTF_IDX_MASK      4'h2
`define DTF_IDX_FDET_CTL  4'h3
`define DTF_IDX_STATUS    4'h4
`define DTF_IDX_RSVD5     4'h5
`define DTF_IDX_BOTH_DT   4'h6
`define DTF_IDX_BOTH_BUF  4'h7
`define DTF_IDX_LO_DT     4'h8
`define DTF_IDX_HI_DT     4'h9
`define DTF_IDX_LO_BUF    4'hA
`define DTF_IDX_HI_BUF    4'hB
`define DTF_IDX_OVEN      4'hC
`define DTF_IDX_LAST      4'hC

// Status fields
`define DTF_ST_FAULT      2
`define DTF_ST_HSV        1
`define DTF_ST_LSV        0

// Control fields
`define DTF_CTRL_MASK     8'h3F
`define DTF_FDET_CTL_MASK 8'h17
`define DTF_FD_MODE       2
`define DTF_FD_IGN_BRK    4
`define DTF_FD_ACT_HI     1
`define DTF_FD_ACT_LO     0
`define DTF_CTRL_PAT      5
`define DTF_CTRL_COM      4
`define DTF_CH_EN_LO      0
`define DTF_CH_EN_HI      3

// Fault action codes
`define DTF_ACT_NONE      2'b00
`define DTF_ACT_CLEARDIR  2'b11

`define DTF_ZERO8         8'h00
`define DTF_ZERO32        32'h0000_0000

`endif

// file: include/dtf_pkg.sv
package dtf_pkg;

	typedef struct packed {
		logic [31:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
		logic [3:0]  pstrb;
	} dtf_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} dtf_apb_rsp_s;

	typedef enum logic [1:0] {
		DTF_NORMAL   = 2'b00,
		DTF_FAULT    = 2'b01,
		DTF_WAIT_UPD = 2'b11
	} dtf_fault_e;

	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] mask;
		logic [7:0] fdet_ctl;
		logic       fault_flag;
		logic       lsv;
		logic       hsv;
		logic [7:0] lo_dt;
		logic [7:0] hi_dt;
		logic [7:0] lo_dt_buf;
		logic [7:0] hi_dt_buf;
		logic [7:0] oven;
	} dtf_regs_s;

endpackage : dtf_pkg
